// [src/enable_brake_sequencer.sv]
// Enable, torque, brake and ready sequencer with AHB-Lite registers
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`default_nettype none
`include "enable_brake_map.svh"
module enable_brake_sequencer #(
  parameter int TICK_CYCLES = `EB_TICK_CYCLES,
  parameter int N_OUTPUTS = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic enable_in_i,
  input wire logic bus_voltage_ok_i,
  output logic power_stage_on_o,
  output logic brake_release_o,
  output logic drive_ready_o,
  output logic [N_OUTPUTS-1:0] gen_out_o
);
  import enable_brake_pkg::*;

  logic tick;
  logic en_db;
  seq_state_t state_reg, state_next;
  ms_count_t cnt_reg, cnt_next;
  ms_count_t debounce_reg, debounce_next;
  ms_count_t torque_dly_reg, torque_dly_next;
  ms_count_t brake_dly_reg, brake_dly_next;
  ms_count_t ready_dly_reg, ready_dly_next;
  ms_count_t off_dly_reg, off_dly_next;
  logic [N_OUTPUTS-1:0] brake_map_reg, brake_map_next;
  logic lowbus_reg, lowbus_next;
  logic power_reg, power_next;
  logic brake_reg, brake_next;
  logic ready_reg, ready_next;
  logic [N_OUTPUTS-1:0] gen_reg, gen_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] addr_reg, addr_next;
  logic [31:0] rdata_reg, rdata_next;

  ms_debouncer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_debounce (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .raw_i(enable_in_i),
    .debounce_ms_i(debounce_reg),
    .tick_o(tick),
    .stable_o(en_db)
  );

  function automatic logic [31:0] status_word(seq_state_t st, logic en, logic lb, logic pw, logic br, logic rd);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`EB_ST_STATE_LSB +: 6] = st;
    w[`EB_ST_EN_BIT] = en;
    w[`EB_ST_LOWBUS_BIT] = lb;
    w[`EB_ST_POWER_BIT] = pw;
    w[`EB_ST_BRAKE_BIT] = br;
    w[`EB_ST_READY_BIT] = rd;
    return w;
  endfunction

  // Sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    power_next = power_reg;
    brake_next = brake_reg;
    ready_next = ready_reg;
    lowbus_next = lowbus_reg;
    if (tick) begin
      cnt_next = cnt_reg + 16'h0001;
    end
    case (state_reg)
      ST_OFF: begin
        cnt_next = 16'h0000;
        if (en_db) begin
          state_next = ST_WAIT_TORQUE;
        end
      end
      ST_WAIT_TORQUE: begin
        if (cnt_reg >= torque_dly_reg) begin
          state_next = ST_WAIT_BRAKE;
          power_next = 1'b1;
          cnt_next = 16'h0000;
        end
      end
      ST_WAIT_BRAKE: begin
        if (cnt_reg >= brake_dly_reg) begin
          brake_next = 1'b1;
          state_next = ST_WAIT_READY;
        end
      end
      ST_WAIT_READY: begin
        // Ready delay counts from power on, same origin as the brake delay
        if (cnt_reg >= brake_dly_reg) begin
          brake_next = 1'b1;
        end
        if (cnt_reg >= ready_dly_reg && cnt_reg >= brake_dly_reg) begin
          ready_next = 1'b1;
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        cnt_next = 16'h0000;
      end
      ST_STOPPING: begin
        if (cnt_reg >= off_dly_reg) begin
          power_next = 1'b0;
          state_next = ST_OFF;
          cnt_next = 16'h0000;
        end
      end
      default: begin
        state_next = ST_OFF;
        power_next = 1'b0;
        brake_next = 1'b0;
        ready_next = 1'b0;
      end
    endcase
    // Enable loss wins over any step of the start sequence
    if (!en_db && state_reg != ST_OFF && state_reg != ST_STOPPING) begin
      brake_next = 1'b0;
      ready_next = 1'b0;
      cnt_next = 16'h0000;
      state_next = power_reg ? ST_STOPPING : ST_OFF;
      power_next = power_reg;
    end
    // Set wins over software clear
    if (wr_pend_reg && addr_reg == `EB_OFS_CTRL && hwdata_i[`EB_CTRL_LOWBUS_CLR]) begin
      lowbus_next = 1'b0;
    end
    if (state_reg == ST_WAIT_TORQUE && power_next && !bus_voltage_ok_i) begin
      lowbus_next = 1'b1;
    end
  end

  // Brake mirrored onto any selected general output
  always_comb begin
    gen_next = brake_map_reg & {N_OUTPUTS{brake_next}};
  end

  // AHB-Lite slave, zero wait states
  always_comb begin
    wr_pend_next = 1'b0;
    addr_next = addr_reg;
    rdata_next = rdata_reg;
    debounce_next = debounce_reg;
    torque_dly_next = torque_dly_reg;
    brake_dly_next = brake_dly_reg;
    ready_dly_next = ready_dly_reg;
    off_dly_next = off_dly_reg;
    brake_map_next = brake_map_reg;
    if (wr_pend_reg) begin
      case (addr_reg)
        `EB_OFS_CTRL: brake_map_next = hwdata_i[N_OUTPUTS-1:0];
        `EB_OFS_DEBOUNCE: debounce_next = hwdata_i[15:0];
        `EB_OFS_TORQUE: torque_dly_next = hwdata_i[15:0];
        `EB_OFS_BRAKE: brake_dly_next = hwdata_i[15:0];
        `EB_OFS_READY: ready_dly_next = hwdata_i[15:0];
        `EB_OFS_MOTOR_OFF: off_dly_next = hwdata_i[15:0];
        default: begin
        end
      endcase
    end
    if (hsel_i && hready_i && htrans_i[1]) begin
      addr_next = {haddr_i[7:2], 2'b00};
      wr_pend_next = hwrite_i;
      case ({haddr_i[7:2], 2'b00})
        `EB_OFS_CTRL: rdata_next = 32'(brake_map_reg);
        `EB_OFS_DEBOUNCE: rdata_next = {16'h0000, debounce_reg};
        `EB_OFS_TORQUE: rdata_next = {16'h0000, torque_dly_reg};
        `EB_OFS_BRAKE: rdata_next = {16'h0000, brake_dly_reg};
        `EB_OFS_READY: rdata_next = {16'h0000, ready_dly_reg};
        `EB_OFS_MOTOR_OFF: rdata_next = {16'h0000, off_dly_reg};
        `EB_OFS_STATUS: rdata_next = status_word(state_reg, en_db, lowbus_reg, power_reg, brake_reg, ready_reg);
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_OFF;
      cnt_reg <= 16'h0000;
      power_reg <= 1'b0;
      brake_reg <= 1'b0;
      ready_reg <= 1'b0;
      lowbus_reg <= 1'b0;
      gen_reg <= '0;
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
      debounce_reg <= `EB_DEBOUNCE_MS_RST;
      torque_dly_reg <= `EB_DELAY_MS_RST;
      brake_dly_reg <= `EB_DELAY_MS_RST;
      ready_dly_reg <= `EB_DELAY_MS_RST;
      off_dly_reg <= `EB_DELAY_MS_RST;
      brake_map_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      power_reg <= power_next;
      brake_reg <= brake_next;
      ready_reg <= ready_next;
      lowbus_reg <= lowbus_next;
      gen_reg <= gen_next;
      wr_pend_reg <= wr_pend_next;
      addr_reg <= addr_next;
      rdata_reg <= rdata_next;
      debounce_reg <= debounce_next;
      torque_dly_reg <= torque_dly_next;
      brake_dly_reg <= brake_dly_next;
      ready_dly_reg <= ready_dly_next;
      off_dly_reg <= off_dly_next;
      brake_map_reg <= brake_map_next;
    end
  end

  assign hrdata_o = rdata_reg;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign power_stage_on_o = power_reg;
  assign brake_release_o = brake_reg;
  assign drive_ready_o = ready_reg;
  assign gen_out_o = gen_reg;
endmodule
`default_nettype wire

// [src/enable_brake_map.svh]
// Offsets, reset values and timing constants of the enable and brake sequencer
`ifndef ENABLE_BRAKE_MAP_SVH
`define ENABLE_BRAKE_MAP_SVH
`define EB_CLK_HZ 20000000
`define EB_TICK_US 1000
`define EB_TICK_CYCLES ((`EB_CLK_HZ / 1000000) * `EB_TICK_US)
`define EB_OFS_CTRL 8'h00
`define EB_OFS_DEBOUNCE 8'h04
`define EB_OFS_TORQUE 8'h08
`define EB_OFS_BRAKE 8'h0C
`define EB_OFS_READY 8'h10
`define EB_OFS_MOTOR_OFF 8'h14
`define EB_OFS_STATUS 8'h18
`define EB_DEBOUNCE_MS_RST 16'h0005
`define EB_DELAY_MS_RST 16'h0000
`define EB_CTRL_RST 8'h00
`define EB_CTRL_LOWBUS_CLR 8
`define EB_ST_STATE_LSB 0
`define EB_ST_EN_BIT 8
`define EB_ST_LOWBUS_BIT 9
`define EB_ST_POWER_BIT 10
`define EB_ST_BRAKE_BIT 11
`define EB_ST_READY_BIT 12
`endif

// [src/enable_brake_pkg.sv]
// Types shared by the enable and brake sequencer
`default_nettype none
package enable_brake_pkg;
  typedef enum logic [5:0] {
    ST_OFF = 6'b00_0001,
    ST_WAIT_TORQUE = 6'b00_0010,
    ST_WAIT_BRAKE = 6'b00_0100,
    ST_WAIT_READY = 6'b00_1000,
    ST_RUN = 6'b01_0000,
    ST_STOPPING = 6'b10_0000
  } seq_state_t;
  typedef logic [15:0] ms_count_t;
endpackage
`default_nettype wire

// [src/ms_debouncer.sv]
// Millisecond tick generator and debouncer for the enable input
`default_nettype none
`include "enable_brake_map.svh"
module ms_debouncer #(
  parameter int TICK_CYCLES = `EB_TICK_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic raw_i,
  input wire enable_brake_pkg::ms_count_t debounce_ms_i,
  output logic tick_o,
  output logic stable_o
);
  import enable_brake_pkg::*;
  logic [15:0] pre_reg, pre_next;
  logic tick_reg, tick_next;
  ms_count_t db_reg, db_next;
  logic stable_reg, stable_next;

  always_comb begin
    pre_next = pre_reg + 16'h0001;
    tick_next = 1'b0;
    if (pre_reg == 16'(TICK_CYCLES - 1)) begin
      pre_next = 16'h0000;
      tick_next = 1'b1;
    end
    db_next = db_reg;
    stable_next = stable_reg;
    // A bounce restarts the interval, so only a steady level is taken
    if (raw_i == stable_reg) begin
      db_next = 16'h0000;
    end else if (db_reg >= debounce_ms_i) begin
      stable_next = raw_i;
      db_next = 16'h0000;
    end else if (tick_reg) begin
      db_next = db_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_reg <= 16'h0000;
      tick_reg <= 1'b0;
      db_reg <= 16'h0000;
      stable_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      tick_reg <= tick_next;
      db_reg <= db_next;
      stable_reg <= stable_next;
    end
  end

  assign tick_o = tick_reg;
  assign stable_o = stable_reg;
endmodule
`default_nettype wire

// [bench/enable_brake_props.sv]
// Assertion checker for the enable and brake sequencer
`default_nettype none
module enable_brake_props #(
  parameter int N_OUTPUTS = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic enable_in_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic power_stage_on_o,
  input wire logic brake_release_o,
  input wire logic drive_ready_o,
  input wire logic [N_OUTPUTS-1:0] gen_out_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Cycles the raw enable has been steady high or low, saturating
  logic [7:0] hi_reg;
  logic [7:0] lo_reg;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hi_reg <= 8'h00;
      lo_reg <= 8'h00;
    end else begin
      hi_reg <= !enable_in_i ? 8'h00 : (hi_reg == 8'hff) ? hi_reg : hi_reg + 8'h01;
      lo_reg <= enable_in_i ? 8'h00 : (lo_reg == 8'hff) ? lo_reg : lo_reg + 8'h01;
    end
  end
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_BUS_OK: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  AST_PWR_DEB: assert property ($rose(power_stage_on_o) |-> hi_reg >= 8'h10)
    else $error("power on before enable settled");
  AST_OFF_DEB: assert property ($fell(power_stage_on_o) |-> lo_reg >= 8'h10)
    else $error("power off without settled disable");
  AST_BRK_PWR: assert property (brake_release_o |-> power_stage_on_o)
    else $error("brake released without power");
  AST_BRK_FIRST: assert property ($fell(power_stage_on_o) |-> !$past(brake_release_o))
    else $error("power removed before brake engaged");
  AST_RDY_BRK: assert property (drive_ready_o |-> brake_release_o)
    else $error("ready while brake engaged");
  AST_DIS_BOUND: assert property (lo_reg == 8'h28 |-> !brake_release_o && !drive_ready_o)
    else $error("brake or ready still on after disable");
  AST_GEN_IDLE: assert property (!brake_release_o [*2] |-> gen_out_o == '0)
    else $error("general output active with brake engaged");
endmodule
bind enable_brake_sequencer enable_brake_props #(.N_OUTPUTS(N_OUTPUTS)) props_u (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .enable_in_i(enable_in_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .power_stage_on_o(power_stage_on_o),
  .brake_release_o(brake_release_o), .drive_ready_o(drive_ready_o), .gen_out_o(gen_out_o)
);
`default_nettype wire

// [bench/enable_source.sv]
// Switch model driving the raw enable, with contact bounce
`default_nettype none
module enable_source (
  input wire logic clk_sys_i,
  output logic enable_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial enable_o = 1'b0;
  // Short bounces first, so the debouncer must restart
  task set_level(input logic v);
    repeat (3) begin
      @(posedge clk_sys_i);
      enable_o <= v;
      repeat (3) @(posedge clk_sys_i);
      enable_o <= !v;
    end
    @(posedge clk_sys_i);
    enable_o <= v;
  endtask
endmodule
`default_nettype wire

// [bench/enable_brake_sequencer_tb.sv]
// Self-checking bench for the enable and brake sequencer
`default_nettype none
module enable_brake_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic hwrite = 1'b0;
  logic bus_ok = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] rd;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, pwr, brk, rdy, en;
  wire logic [7:0] gen;
  int err_count = 0;
  int total_checks = 0;
  int n;
  always #25 clk_sys_i = ~clk_sys_i;
  enable_source src_u (.clk_sys_i(clk_sys_i), .enable_o(en));
  // Short tick keeps millisecond delays to a few cycles
  enable_brake_sequencer #(.TICK_CYCLES(4)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .enable_in_i(en), .bus_voltage_ok_i(bus_ok), .power_stage_on_o(pwr),
    .brake_release_o(brk), .drive_ready_o(rdy), .gen_out_o(gen)
  );
  task results;
    $display("mismatches %0d of %0d checks", err_count, total_checks);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded wait on power, brake, ready or bus ready; n counts edges
  task wait_sig(input int sel, input logic v);
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while ((sel == 0 ? pwr : sel == 1 ? brk : sel == 2 ? rdy : hready) !== v && n < 2000);
    if (n >= 2000) begin
      err_count++;
      results();
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    wait_sig(3, 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_sig(3, 1'b1);
    rd = hrdata;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rdchk(8'h04, 32'h0000_0005);
    rdchk(8'h08, 32'h0000_0000);
    rdchk(8'h18, 32'h0000_0001);
    rdchk(8'h1C, 32'h0000_0000);
    ahb(1'b1, 8'h00, 32'h0000_0081);
    ahb(1'b1, 8'h08, 32'h0000_0002);
    ahb(1'b1, 8'h0C, 32'h0000_0003);
    ahb(1'b1, 8'h10, 32'h0000_0005);
    ahb(1'b1, 8'h14, 32'h0000_0002);
    rdchk(8'h0C, 32'h0000_0003);
    rdchk(8'h00, 32'h0000_0081);
    rdchk(8'h10, 32'h0000_0005);
    rdchk(8'h14, 32'h0000_0002);
    src_u.set_level(1'b1);
    wait_sig(0, 1'b1);
    chk(32'(brk), 32'h0000_0000);
    wait_sig(1, 1'b1);
    chk(32'(n inside {[8:16]}), 32'h0000_0001);
    wait_sig(2, 1'b1);
    chk(32'(n inside {[4:12]}), 32'h0000_0001);
    chk(32'(gen), 32'h0000_0081);
    rdchk(8'h18, 32'h0000_1F10);
    bus_ok <= 1'b1;
    ahb(1'b1, 8'h00, 32'h0000_0181);
    rdchk(8'h18, 32'h0000_1D10);
    src_u.set_level(1'b0);
    wait_sig(1, 1'b0);
    chk(32'(rdy), 32'h0000_0000);
    chk(32'(pwr), 32'h0000_0001);
    wait_sig(0, 1'b0);
    chk(32'(n inside {[4:12]}), 32'h0000_0001);
    chk(32'(gen), 32'h0000_0000);
    // Long torque delay so the drop lands mid-sequence
    ahb(1'b1, 8'h08, 32'h0000_0014);
    src_u.set_level(1'b1);
    repeat (50) @(posedge clk_sys_i);
    src_u.set_level(1'b0);
    repeat (200) @(posedge clk_sys_i);
    chk(32'(pwr), 32'h0000_0000);
    rdchk(8'h18, 32'h0000_0001);
    // Mid-run reset must bring back the default torque delay and map
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rdchk(8'h08, 32'h0000_0000);
    rdchk(8'h00, 32'h0000_0000);
    rdchk(8'h18, 32'h0000_0001);
    results();
  end
endmodule
`default_nettype wire
